// File: verilog/rtc_supervisor_defs.vh
`ifndef RTC_SUPERVISOR_DEFS_VH
`define RTC_SUPERVISOR_DEFS_VH

// ==========================================================
// clock and timing
`define CLK_KHZ          32'h0001_e848
`define RECOVERY_MS      32'h0000_00fa
`define START_DELAY_S    4'h2
`define BAT_CORR_S       4'ha
`define PIN_SETTLE_CYC   32'h0000_0004
`define DEB_CYC_DEF      32'h0013_12d0
`define PULSE_CYC_DEF    32'h017d_7840

// ==========================================================
// reset pin controller states
`define RP_PFAIL         3'h0
`define RP_REC           3'h1
`define RP_IDLE          3'h2
`define RP_DEB           3'h3
`define RP_CHECK         3'h4
`define RP_WREL          3'h5
`define RP_PULSE         3'h6
`define RP_OFF           3'h7

// ==========================================================
// time base controller states
`define TB_STOP          2'h0
`define TB_RUN           2'h1
`define TB_CONV          2'h2

// ==========================================================
// default calendar, bcd: yy mm dd dow hh mi ss
`define DEF_YEAR         8'h00
`define DEF_MONTH        8'h01
`define DEF_DATE         8'h01
`define DEF_DOW          8'h01
`define DEF_HOUR         8'h00
`define DEF_MIN          8'h00
`define DEF_SEC          8'h00

`endif

// File: verilog/sync_2ff.v
// ==========================================================
// two flip-flop synchroniser, one chain per bit
module sync_2ff #(
  parameter WIDTH = 4
) (
  input  wire             clk_i,   // system clock
  input  wire             rst_b_i, // sync reset, active low
  input  wire [WIDTH-1:0] async_i, // asynchronous levels
  output wire [WIDTH-1:0] sync_o   // synchronised levels
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= async_i[gi];
          sync_ff <= meta_ff;
        end
      end
      assign sync_o[gi] = sync_ff;
    end
  endgenerate

endmodule

// File: verilog/rtc_power_reset_supervisor.v
`include "rtc_supervisor_defs.vh"

// Summary of operation
// R01 - on main supply, convert temperature and correct the 1 Hz base every second
// R02 - on backup supply, convert and correct only every tenth second
// R03 - correction is factory-trimmed value plus signed aging offset
// R04 - main below power-fail threshold drives the reset pin low
// R05 - backup-only with main grounded: reset output disabled, left at ground
// R06 - main selected if above threshold or above backup, else backup
// R07 - conversions each second on main, each ten seconds on backup
// R08 - oscillator stays stopped after first power until main good or address write
// R09 - two seconds after main power or address write, measure and correct
// R10 - once started, oscillator and periodic correction run while any supply valid
// R11 - first main power-up, or first address write on battery, loads default time
// R12 - oscillator stop bit set halts oscillator and timekeeping, keeps registers
// R13 - outside a reset cycle, falling pin edge drives pin low for debounce
// R14 - pin still low after debounce: wait for release, then drive reset pulse
// R15 - main returning above threshold holds pin low for about 250 ms
// R16 - oscillator not running at main power-up: skip recovery, release immediately
// R17 - driving reset low never disturbs timekeeping or other internal work
// R18 - reset drive and pushbutton watch only while main supply present
// R19 - debounce and reset pulse lengths are parameter cycle counts
module rtc_power_reset_supervisor #(
  parameter RECOVERY_CYCLES = `RECOVERY_MS * `CLK_KHZ, // recovery hold
  parameter DEB_CYCLES      = `DEB_CYC_DEF,            // pushbutton debounce
  parameter PULSE_CYCLES    = `PULSE_CYC_DEF,          // reset pulse after release
  parameter CORR_W          = 8                        // correction word width
) (
  input  wire              clk_i,             // 125 MHz clock
  input  wire              rst_b_i,           // sync reset, active low
  input  wire              vcc_above_pf_i,    // comparator: main above threshold
  input  wire              vcc_above_bat_i,   // comparator: main above backup
  input  wire              vcc_present_i,     // comparator: main not grounded
  input  wire              rst_pin_i,         // reset pin level
  output wire              rst_pin_o,         // reset pin drive value (low)
  output wire              rst_pin_oe_o,      // reset pin drive enable
  input  wire              addr_wr_i,         // valid serial address written
  input  wire              osc_stop_bit_i,    // oscillator stop control bit
  input  wire              sec_tick_i,        // 1 Hz tick of the time base
  input  wire              conv_done_i,       // temperature conversion done
  input  wire [CORR_W-1:0] trim_corr_i,       // factory-trimmed correction
  input  wire [CORR_W-1:0] aging_offset_i,    // signed aging offset
  output wire              on_backup_o,       // backup supply selected
  output wire              osc_run_o,         // oscillator running
  output wire              conv_start_o,      // start temperature conversion
  output wire              corr_apply_o,      // apply correction pulse
  output wire [CORR_W:0]   corr_value_o,      // signed correction value
  output wire              load_default_o,    // load default time pulse
  output wire [55:0]       default_time_o     // default calendar in bcd
);

  // ==========================================================
  // input synchronisers
  wire [3:0] pin_sync;
  wire       vcc_good;
  wire       vcc_over_bat;
  wire       vcc_here;
  wire       pin_level;

  sync_2ff #(
    .WIDTH (4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({rst_pin_i, vcc_present_i, vcc_above_bat_i, vcc_above_pf_i}),
    .sync_o  (pin_sync)
  );

  assign vcc_good     = pin_sync[0];
  assign vcc_over_bat = pin_sync[1];
  assign vcc_here     = pin_sync[2];
  assign pin_level    = pin_sync[3];

  // ==========================================================
  // supply selection
  reg vcc_good_ff;
  reg on_backup_ff;
  reg pin_prev_ff;

  wire vcc_rise = vcc_good & ~vcc_good_ff;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      vcc_good_ff  <= 1'b0;
      on_backup_ff <= 1'b1;
      pin_prev_ff  <= 1'b1;
    end else begin
      vcc_good_ff  <= vcc_good;
      on_backup_ff <= ~(vcc_good | vcc_over_bat); // [R06]
      pin_prev_ff  <= pin_level;
    end
  end

  assign on_backup_o = on_backup_ff;

  // ==========================================================
  // oscillator start and default time load
  reg        started_ff;
  reg        defaults_done_ff;
  reg        load_default_ff;
  reg [55:0] default_time_ff;

  wire start_evt  = vcc_rise | addr_wr_i;
  wire osc_run    = started_ff & ~osc_stop_bit_i; // [R12]
  wire load_evt   = ~defaults_done_ff & (vcc_good | (addr_wr_i & on_backup_ff));

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      started_ff       <= 1'b0;
      defaults_done_ff <= 1'b0;
      load_default_ff  <= 1'b0;
      default_time_ff  <= 56'h0000_0000_0000_00;
    end else begin
      // stays stopped until main good or a valid address write
      if (vcc_good | addr_wr_i) begin
        started_ff <= 1'b1; // [R08]
      end
      // never cleared while any supply keeps the logic alive
      load_default_ff <= load_evt; // [R11]
      if (load_evt) begin
        defaults_done_ff <= 1'b1;
        default_time_ff  <= {`DEF_YEAR, `DEF_MONTH, `DEF_DATE, `DEF_DOW,
                             `DEF_HOUR, `DEF_MIN, `DEF_SEC}; // [R11]
      end
    end
  end

  assign osc_run_o      = osc_run;
  assign load_default_o = load_default_ff;
  assign default_time_o = default_time_ff;

  // ==========================================================
  // time base correction scheduler
  reg [1:0]        tb_state_ff;
  reg [1:0]        nxt_tb_state;
  reg [3:0]        sec_cnt_ff;
  reg [3:0]        nxt_sec_cnt;
  reg [3:0]        start_cnt_ff;
  reg [3:0]        nxt_start_cnt;
  reg              conv_start_ff;
  reg              nxt_conv_start;
  reg              corr_apply_ff;
  reg              nxt_corr_apply;
  reg [CORR_W:0]   corr_value_ff;
  reg [CORR_W:0]   nxt_corr_value;

  wire [CORR_W:0] trim_ext  = {trim_corr_i[CORR_W-1], trim_corr_i};
  wire [CORR_W:0] aging_ext = {aging_offset_i[CORR_W-1], aging_offset_i};

  // period in seconds follows the selected supply
  wire period_due = on_backup_ff ? (sec_cnt_ff >= `BAT_CORR_S - 4'h1) : 1'b1;

  // scheduler reads no reset pin state, so pin activity never stalls it
  always @* begin
    nxt_tb_state   = tb_state_ff;
    nxt_sec_cnt    = sec_cnt_ff;
    nxt_start_cnt  = start_cnt_ff;
    nxt_conv_start = 1'b0;
    nxt_corr_apply = 1'b0;
    nxt_corr_value = corr_value_ff;
    case (tb_state_ff)
      `TB_STOP: begin
        nxt_sec_cnt   = 4'h0;
        nxt_start_cnt = 4'h0;
        if (osc_run) begin
          nxt_tb_state  = `TB_RUN;
          nxt_start_cnt = `START_DELAY_S; // [R09]
        end
      end
      `TB_RUN: begin
        if (!osc_run) begin
          nxt_tb_state = `TB_STOP; // [R12]
        end else begin
          if (start_evt) begin
            nxt_start_cnt = `START_DELAY_S; // [R09]
          end
          if (sec_tick_i) begin
            if (start_cnt_ff != 4'h0) begin
              nxt_start_cnt = start_cnt_ff - 4'h1;
              if (start_cnt_ff == 4'h1) begin
                nxt_conv_start = 1'b1; // [R09]
                nxt_sec_cnt    = 4'h0;
                nxt_tb_state   = `TB_CONV;
              end
            end else if (period_due) begin
              nxt_conv_start = 1'b1; // [R01] [R02] [R07] [R10]
              nxt_sec_cnt    = 4'h0;
              nxt_tb_state   = `TB_CONV;
            end else begin
              nxt_sec_cnt = sec_cnt_ff + 4'h1; // [R02]
            end
          end
        end
      end
      `TB_CONV: begin
        if (!osc_run) begin
          nxt_tb_state = `TB_STOP;
        end else begin
          if (start_evt) begin
            nxt_start_cnt = `START_DELAY_S;
          end
          if (conv_done_i) begin
            nxt_corr_value = trim_ext + aging_ext; // [R03]
            nxt_corr_apply = 1'b1;                 // [R01] [R02]
            nxt_tb_state   = `TB_RUN;
          end
        end
      end
      default: begin
        nxt_tb_state = `TB_STOP;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      tb_state_ff   <= `TB_STOP;
      sec_cnt_ff    <= 4'h0;
      start_cnt_ff  <= 4'h0;
      conv_start_ff <= 1'b0;
      corr_apply_ff <= 1'b0;
      corr_value_ff <= {(CORR_W+1){1'b0}};
    end else begin
      tb_state_ff   <= nxt_tb_state;
      sec_cnt_ff    <= nxt_sec_cnt;
      start_cnt_ff  <= nxt_start_cnt;
      conv_start_ff <= nxt_conv_start;
      corr_apply_ff <= nxt_corr_apply;
      corr_value_ff <= nxt_corr_value;
    end
  end

  assign conv_start_o = conv_start_ff;
  assign corr_apply_o = corr_apply_ff;
  assign corr_value_o = corr_value_ff;

  // ==========================================================
  // reset pin controller
  localparam [31:0] REC_LIM   = RECOVERY_CYCLES;
  localparam [31:0] DEB_LIM   = DEB_CYCLES;
  localparam [31:0] PULSE_LIM = PULSE_CYCLES;

  reg [2:0]  rp_state_ff;
  reg [2:0]  nxt_rp_state;
  reg [31:0] rp_cnt_ff;
  reg [31:0] nxt_rp_cnt;
  reg        drive_low_ff;
  reg        nxt_drive_low;

  wire pin_fall = pin_prev_ff & ~pin_level;
  wire pin_rise = ~pin_prev_ff & pin_level;

  always @* begin
    nxt_rp_state  = rp_state_ff;
    nxt_rp_cnt    = rp_cnt_ff;
    nxt_drive_low = 1'b0;
    case (rp_state_ff)
      `RP_OFF: begin
        // main grounded: pin left to the pull-up, which sits at ground
        if (vcc_here) begin
          nxt_rp_state  = `RP_PFAIL;
          nxt_drive_low = 1'b1;
        end
      end
      `RP_PFAIL: begin
        nxt_drive_low = 1'b1; // [R04]
        nxt_rp_cnt    = 32'h0000_0000;
        if (vcc_good) begin
          if (osc_run) begin
            nxt_rp_state = `RP_REC; // [R15]
          end else begin
            nxt_rp_state  = `RP_IDLE; // [R16]
            nxt_drive_low = 1'b0;
          end
        end
      end
      `RP_REC: begin
        nxt_drive_low = 1'b1; // [R15]
        nxt_rp_cnt    = rp_cnt_ff + 32'h0000_0001;
        if (rp_cnt_ff >= REC_LIM - 32'h0000_0001) begin
          nxt_rp_state  = `RP_IDLE;
          nxt_drive_low = 1'b0;
          nxt_rp_cnt    = 32'h0000_0000;
        end
      end
      `RP_IDLE: begin
        nxt_rp_cnt = 32'h0000_0000;
        if (pin_fall) begin
          nxt_rp_state  = `RP_DEB; // [R13]
          nxt_drive_low = 1'b1;
        end
      end
      `RP_DEB: begin
        nxt_drive_low = 1'b1; // [R13] [R19]
        nxt_rp_cnt    = rp_cnt_ff + 32'h0000_0001;
        if (rp_cnt_ff >= DEB_LIM - 32'h0000_0001) begin
          nxt_rp_state  = `RP_CHECK;
          nxt_drive_low = 1'b0;
          nxt_rp_cnt    = 32'h0000_0000;
        end
      end
      `RP_CHECK: begin
        // let the pin and synchroniser settle after our own drive ends
        nxt_rp_cnt = rp_cnt_ff + 32'h0000_0001;
        if (rp_cnt_ff >= `PIN_SETTLE_CYC) begin
          nxt_rp_cnt = 32'h0000_0000;
          if (!pin_level) begin
            nxt_rp_state = `RP_WREL; // [R14]
          end else begin
            nxt_rp_state = `RP_IDLE;
          end
        end
      end
      `RP_WREL: begin
        nxt_rp_cnt = 32'h0000_0000;
        if (pin_rise) begin
          nxt_rp_state  = `RP_PULSE; // [R14]
          nxt_drive_low = 1'b1;
        end
      end
      `RP_PULSE: begin
        nxt_drive_low = 1'b1; // [R14] [R19]
        nxt_rp_cnt    = rp_cnt_ff + 32'h0000_0001;
        if (rp_cnt_ff >= PULSE_LIM - 32'h0000_0001) begin
          nxt_rp_state  = `RP_CHECK;
          nxt_drive_low = 1'b0;
          nxt_rp_cnt    = 32'h0000_0000;
        end
      end
      default: begin
        nxt_rp_state = `RP_PFAIL;
      end
    endcase
    // supply loss overrides any pushbutton cycle
    if (!vcc_here) begin
      nxt_rp_state  = `RP_OFF; // [R05] [R18]
      nxt_drive_low = 1'b0;
      nxt_rp_cnt    = 32'h0000_0000;
    end else if (!vcc_good) begin
      nxt_rp_state  = `RP_PFAIL; // [R04] [R18]
      nxt_drive_low = 1'b1;
      nxt_rp_cnt    = 32'h0000_0000;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rp_state_ff  <= `RP_OFF;
      rp_cnt_ff    <= 32'h0000_0000;
      drive_low_ff <= 1'b0;
    end else begin
      rp_state_ff  <= nxt_rp_state;
      rp_cnt_ff    <= nxt_rp_cnt;
      drive_low_ff <= nxt_drive_low;
    end
  end

  // open drain: only ever drives low; the pin itself never feeds timekeeping
  assign rst_pin_o    = 1'b0;         // [R17]
  assign rst_pin_oe_o = drive_low_ff;

endmodule

// File: sim/sup_props.sv
// ========
// supervisor checker
module sup_props #(
  parameter CORR_W = 8
) (
  input logic              clk_i,           // clock
  input logic              rst_b_i,         // reset
  input logic              vcc_above_pf_i,  // main good
  input logic              vcc_above_bat_i, // main over backup
  input logic              vcc_present_i,   // main present
  input logic              rst_pin_o,       // pin value
  input logic              rst_pin_oe_o,    // pin drive
  input logic              osc_stop_bit_i,  // stop bit
  input logic              sec_tick_i,      // tick
  input logic              conv_done_i,     // conv done
  input logic [CORR_W-1:0] trim_corr_i,     // trim
  input logic [CORR_W-1:0] aging_offset_i,  // aging
  input logic              on_backup_o,     // backup
  input logic              osc_run_o,       // osc running
  input logic              conv_start_o,    // conv start
  input logic              corr_apply_o,    // apply
  input logic [CORR_W:0]   corr_value_o,    // correction
  input logic              load_default_o,  // load
  input logic [55:0]       default_time_o   // calendar
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CORR_W:0] exp_corr;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  always_ff @(posedge clk_i) begin
    exp_corr <= {trim_corr_i[CORR_W-1], trim_corr_i} + {aging_offset_i[CORR_W-1], aging_offset_i};
  end
  sequence s_pf_low; (vcc_present_i && !vcc_above_pf_i) [*6]; endsequence
  sequence s_gone; (!vcc_present_i) [*6]; endsequence
  sequence s_main; (vcc_above_pf_i || vcc_above_bat_i) [*5]; endsequence
  sequence s_bat; (!vcc_above_pf_i && !vcc_above_bat_i) [*5]; endsequence
  sequence s_once; (!load_default_o) [*8]; endsequence
  property p_drive_low; rst_pin_o == 1'b0; endproperty
  property p_pf_oe; s_pf_low |-> rst_pin_oe_o; endproperty
  property p_gone; s_gone |-> !rst_pin_oe_o; endproperty
  property p_main; s_main |-> !on_backup_o; endproperty
  property p_bat; s_bat |-> on_backup_o; endproperty
  property p_conv; conv_start_o |-> $past(sec_tick_i) && $past(osc_run_o); endproperty
  property p_apply; corr_apply_o |-> $past(conv_done_i); endproperty
  property p_corr; corr_apply_o |-> corr_value_o == exp_corr; endproperty
  property p_stop; osc_stop_bit_i |-> !osc_run_o; endproperty
  property p_default; load_default_o |-> (default_time_o == 56'h00_0101_0100_0000) ##1 s_once; endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin driven high");
  a_pf_oe: assert property (p_pf_oe) else $error("no pin drive on power fail");
  a_gone: assert property (p_gone) else $error("pin driven without main");
  a_main: assert property (p_main) else $error("backup while main usable");
  a_bat: assert property (p_bat) else $error("main kept while too low");
  a_conv: assert property (p_conv) else $error("conversion without tick");
  a_apply: assert property (p_apply) else $error("apply without done");
  a_corr: assert property (p_corr) else $error("bad correction sum");
  a_stop: assert property (p_stop) else $error("osc runs while stopped");
  a_default: assert property (p_default) else $error("bad default load");
endmodule

bind rtc_power_reset_supervisor sup_props #(.CORR_W(CORR_W)) props (
  .clk_i, .rst_b_i, .vcc_above_pf_i, .vcc_above_bat_i, .vcc_present_i, .rst_pin_o, .rst_pin_oe_o,
  .osc_stop_bit_i, .sec_tick_i, .conv_done_i, .trim_corr_i, .aging_offset_i, .on_backup_o, .osc_run_o,
  .conv_start_o, .corr_apply_o, .corr_value_o, .load_default_o, .default_time_o
);

// File: sim/rst_pin_host.sv
// ========
// reset wire, host input and pushbutton
module rst_pin_host (
  input  logic vcc_present_i, // main present
  input  logic dev_oe_i,      // device pulls low
  input  logic btn_i,         // button pressed
  output logic pin_o          // wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up goes to main supply, so the wire sits at ground without it
  assign pin_o = vcc_present_i & !(dev_oe_i | btn_i);
endmodule

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_b_i = 0, vcc_above_pf_i = 0, vcc_above_bat_i = 0, vcc_present_i = 0;
  logic        addr_wr_i = 0, osc_stop_bit_i = 0, sec_tick_i = 0, conv_done_i = 0, btn = 0;
  logic [7:0]  trim_corr_i = 8'h00, aging_offset_i = 8'h00;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe_o, on_backup_o, osc_run_o;
  logic        conv_start_o, corr_apply_o, load_default_o;
  logic [8:0]  corr_value_o;
  logic [55:0] default_time_o;
  int          err_total = 0, total_checks = 0, n, c;

  always #4 clk_i = ~clk_i;

  rtc_power_reset_supervisor #(.RECOVERY_CYCLES(40), .DEB_CYCLES(20), .PULSE_CYCLES(30)) uut (
    .clk_i, .rst_b_i, .vcc_above_pf_i, .vcc_above_bat_i, .vcc_present_i, .rst_pin_i, .rst_pin_o,
    .rst_pin_oe_o, .addr_wr_i, .osc_stop_bit_i, .sec_tick_i, .conv_done_i, .trim_corr_i,
    .aging_offset_i, .on_backup_o, .osc_run_o, .conv_start_o, .corr_apply_o, .corr_value_o,
    .load_default_o, .default_time_o
  );
  rst_pin_host host (.vcc_present_i, .dev_oe_i(rst_pin_oe_o), .btn_i(btn), .pin_o(rst_pin_i));

  // ========
  // helpers
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task oe_len(output int k);
    k = 0;
    while (rst_pin_oe_o === 1'b1 && k < 200) begin
      k++;
      cyc(1);
    end
  endtask
  task wait_load;
    n = 0;
    while (load_default_o !== 1'b1 && n < 8) begin
      n++;
      cyc(1);
    end
  endtask
  // k ticks; answer each conversion request and judge the correction
  task ticks(input int k, output int cnt);
    int i, j, v;
    logic [8:0] e;
    cnt = 0;
    for (i = 0; i < k; i++) begin
      v = 0;
      sec_tick_i = 1;
      cyc(1);
      sec_tick_i = 0;
      for (j = 0; j < 3; j++) begin
        if (conv_start_o === 1'b1) v = 1;
        cyc(1);
      end
      if (v == 1) begin
        e = {trim_corr_i[7], trim_corr_i} + {aging_offset_i[7], aging_offset_i};
        conv_done_i = 1;
        cyc(1);
        conv_done_i = 0;
        chk(corr_apply_o, 1'b1);
        chk(corr_value_o, e);
      end
      cnt += v;
      cyc(3);
    end
  endtask
  task do_reset;
    rst_b_i = 0;
    cyc(16);
    rst_b_i = 1;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ========
  // scenarios
  task t_power_up;
    vcc_present_i = 1;
    vcc_above_bat_i = 1;
    cyc(8);
    chk(rst_pin_oe_o, 1'b1);
    chk(osc_run_o, 1'b0);
    chk(on_backup_o, 1'b0);
    vcc_above_pf_i = 1;
    wait_load;
    chk(load_default_o, 1'b1);
    chk(default_time_o, 56'h00_0101_0100_0000);
    oe_len(n);
    chk(n, 0);
    chk(osc_run_o, 1'b1);
    $display("test power_up done");
  endtask
  task t_main_conv;
    trim_corr_i = 8'hf0;
    aging_offset_i = 8'h05;
    // let the scheduler leave its stopped state before the first tick
    cyc(2);
    ticks(1, c);
    chk(c, 0);
    ticks(1, c);
    chk(c, 1);
    trim_corr_i = 8'h80;
    aging_offset_i = 8'hff;
    ticks(3, c);
    chk(c, 3);
    $display("test main_conv done");
  endtask
  task t_button;
    btn = 1;
    cyc(5);
    chk(rst_pin_oe_o, 1'b1);
    ticks(1, c);
    chk(c, 1);
    cyc(26);
    chk(rst_pin_oe_o, 1'b0);
    btn = 0;
    cyc(5);
    chk(rst_pin_i, 1'b0);
    oe_len(n);
    chk(n >= 25 && n <= 31, 1'b1);
    cyc(10);
    $display("test button done");
  endtask
  task t_backup;
    vcc_above_pf_i = 0;
    vcc_above_bat_i = 0;
    cyc(8);
    chk(on_backup_o, 1'b1);
    chk(rst_pin_oe_o, 1'b1);
    ticks(20, c);
    chk(c, 2);
    vcc_above_bat_i = 1;
    cyc(8);
    chk(on_backup_o, 1'b0);
    ticks(1, c);
    chk(c, 1);
    vcc_above_bat_i = 0;
    vcc_present_i = 0;
    cyc(8);
    chk(rst_pin_oe_o, 1'b0);
    chk(rst_pin_i, 1'b0);
    btn = 1;
    cyc(8);
    btn = 0;
    chk(rst_pin_oe_o, 1'b0);
    chk(osc_run_o, 1'b1);
    $display("test backup done");
  endtask
  task t_osc_stop;
    vcc_present_i = 1;
    vcc_above_bat_i = 1;
    vcc_above_pf_i = 1;
    cyc(4);
    oe_len(n);
    chk(n >= 38 && n <= 42, 1'b1);
    cyc(4);
    osc_stop_bit_i = 1;
    cyc(1);
    chk(osc_run_o, 1'b0);
    ticks(3, c);
    chk(c, 0);
    osc_stop_bit_i = 0;
    cyc(1);
    ticks(2, c);
    chk(c, 1);
    $display("test osc_stop done");
  endtask
  task t_first_battery;
    vcc_present_i = 0;
    vcc_above_pf_i = 0;
    vcc_above_bat_i = 0;
    do_reset;
    cyc(8);
    chk(osc_run_o, 1'b0);
    ticks(2, c);
    chk(c, 0);
    addr_wr_i = 1;
    cyc(1);
    addr_wr_i = 0;
    wait_load;
    chk(load_default_o, 1'b1);
    chk(osc_run_o, 1'b1);
    cyc(2);
    ticks(2, c);
    chk(c, 1);
    $display("test first_battery done");
  endtask
  task t_no_osc;
    osc_stop_bit_i = 1;
    vcc_present_i = 1;
    vcc_above_bat_i = 1;
    cyc(8);
    vcc_above_pf_i = 1;
    cyc(4);
    oe_len(n);
    chk(n <= 2, 1'b1);
    osc_stop_bit_i = 0;
    $display("test no_osc done");
  endtask

  initial begin
    do_reset;
    t_power_up;
    t_main_conv;
    t_button;
    t_backup;
    t_osc_stop;
    t_first_battery;
    t_no_osc;
    end_of_test;
  end
  // run needs a few hundred cycles; allow twenty thousand
  initial begin
    #160000;
    err_total++;
    end_of_test;
  end
endmodule
